// file: tqd_pkg.sv
// Package: register map, field layout, reset values and bus carriers of the quadrature decoder
//
// Behaviour
// - Interrupt pends once any axis sees threshold field plus one events; field 10:3, reset 0x2.
// - Pending flag at control bit 2 reads 1 after interrupt; writing 1 clears it.
// - Writing 1 to control bit 1 zeroes the event tally; the bit reads zero.
// - Unmask bit 0 at zero keeps the interrupt from the processor.
// - Unmask bit 0 at one delivers the interrupt; it resets to 0x1.
// - X and Y counts read as signed 16-bit values, reset zero, read-only.
// - An axis count reads zero while no pin pair is selected for it.
// - Control, X count and Y count decode at 0x50000200, 0x50000202, 0x50000204.
// - Divider, pin select and Z count decode at 0x50000206, 0x50000208, 0x5000020A.
// - Logic clock is input clock divided by divider plus one; bypassed on low-power clock.
// - Edge mode, default, counts every edge of both phases; simultaneous changes count once.
// - Three-bit selector maps one of six pin pairs per axis; 0 and 7 select none.
// - Read-only 8-bit event tally counts events across all channels.
`default_nettype none
package tqd_pkg;

  // ****************************************************************
  // Register map (offsets are register indices; byte address is 4x from base)
  // ****************************************************************
  localparam logic [31:0] TQD_BASE_IDX = 32'h50000200;
  localparam logic [31:0] TQD_CTRL_IDX = 32'h50000200;
  localparam logic [31:0] TQD_XCNT_IDX = 32'h50000202;
  localparam logic [31:0] TQD_YCNT_IDX = 32'h50000204;
  localparam logic [31:0] TQD_DIV_IDX = 32'h50000206;
  localparam logic [31:0] TQD_SEL_IDX = 32'h50000208;
  localparam logic [31:0] TQD_ZCNT_IDX = 32'h5000020a;
  localparam logic [31:0] TQD_TALLY_IDX = 32'h5000020c;
  localparam int TQD_ADDR_W = 12;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int TQD_CTRL_UNMASK_BIT = 0;
  localparam int TQD_CTRL_TCLR_BIT = 1;
  localparam int TQD_CTRL_PEND_BIT = 2;
  localparam int TQD_CTRL_THR_LSB = 3;
  localparam int TQD_CTRL_THR_MSB = 10;
  localparam logic [7:0] TQD_THR_RST = 8'h02;
  localparam logic TQD_UNMASK_RST = 1'b1;
  localparam int TQD_DIV_MSB = 9;
  localparam int TQD_DIV_PRESC_BIT = 10;
  localparam logic [9:0] TQD_DIV_RST = 10'h3e7;
  localparam logic TQD_PRESC_RST = 1'b0;
  localparam int TQD_SEL_X_LSB = 0;
  localparam int TQD_SEL_Y_LSB = 3;
  localparam int TQD_SEL_Z_LSB = 6;
  localparam int TQD_MODE_X_BIT = 9;
  localparam logic [11:0] TQD_SEL_RST = 12'hed1;
  localparam int TQD_AXES = 3;
  localparam int TQD_PINS = 12;

  // Pin pair table, entry 0 unused; selectors 0 and 7 mean no pins
  localparam logic [3:0] TQD_PIN_A [0:6] = '{4'h0, 4'h2, 4'h1, 4'h3, 4'h6, 4'h8, 4'h0};
  localparam logic [3:0] TQD_PIN_B [0:6] = '{4'h0, 4'h5, 4'h4, 4'ha, 4'h7, 4'h9, 4'hb};

  localparam logic [1:0] TQD_RESP_OKAY = 2'h0;
  localparam logic [1:0] TQD_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // AXI4-Lite carriers
  // ****************************************************************
  typedef struct packed {
    logic [TQD_ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [TQD_ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } tqd_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } tqd_axi_rsp_t;

  function automatic logic [TQD_ADDR_W-1:0] tqd_byte_addr(input logic [31:0] idx);
    logic [31:0] rel;
    rel = (idx - TQD_BASE_IDX) << 2;
    return rel[TQD_ADDR_W-1:0];
  endfunction

endpackage
`default_nettype wire

// file: tqd_decoder.sv
// Three-axis quadrature decoder with AXI4-Lite register slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// One axis: pin pair selection, phase decode, count, event gauge
// ****************************************************************
module tqd_axis
  import tqd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [2:0] pinSel,
  input wire logic edgeMode,
  input wire logic [TQD_PINS-1:0] pins,
  input wire logic [7:0] threshold,
  input wire logic gaugeClear,
  output logic [15:0] count,
  output logic event_,
  output logic hit
);
  logic enabled, phaseA, phaseB, prevA, prevB, stepUp, stepDown;
  logic [7:0] gauge;
  logic [3:0] trans;

  always_comb begin
    enabled = (pinSel != 3'h0) && (pinSel != 3'h7);
    phaseA = 1'b0;
    phaseB = 1'b0;
    if (enabled) begin
      phaseA = pins[TQD_PIN_A[pinSel]];
      phaseB = pins[TQD_PIN_B[pinSel]];
    end
    trans = {prevA, prevB, phaseA, phaseB};
    stepUp = 1'b0;
    stepDown = 1'b0;
    if (tick && enabled) begin
      if (edgeMode) begin
        stepUp = (phaseA != prevA) || (phaseB != prevB);
      end else begin
        // Double changes are illegal in quadrature and are dropped
        stepUp = (trans == 4'h1) || (trans == 4'h7) || (trans == 4'he) || (trans == 4'h8);
        stepDown = (trans == 4'h2) || (trans == 4'hb) || (trans == 4'hd) || (trans == 4'h4);
      end
    end
    event_ = stepUp || stepDown;
    hit = event_ && (gauge >= threshold);
  end

  // Phase history is loaded with the forced-low phases while disabled, so a new selection starts from zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prevA <= 1'b0;
      prevB <= 1'b0;
    end else if (tick || !enabled) begin
      prevA <= phaseA;
      prevB <= phaseB;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count <= 16'h0000;
    end else if (!enabled) begin
      count <= 16'h0000;
    end else if (stepUp) begin
      count <= count + 16'h0001;
    end else if (stepDown) begin
      count <= count - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gauge <= 8'h00;
    end else if (gaugeClear) begin
      gauge <= 8'h00;
    end else if (event_) begin
      gauge <= gauge + 8'h01;
    end
  end
endmodule // tqd_axis

// ****************************************************************
// Top: register slave, divider, tally, interrupt
// ****************************************************************
module tqd_decoder
  import tqd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire tqd_axi_req_t axiReq,
  output tqd_axi_rsp_t axiRsp,
  input wire logic [TQD_PINS-1:0] gpioIn,
  input wire logic lowPowerClock,
  output logic irq
);
  localparam logic [TQD_ADDR_W-1:0] A_CTRL = tqd_byte_addr(TQD_CTRL_IDX);
  localparam logic [TQD_ADDR_W-1:0] A_XCNT = tqd_byte_addr(TQD_XCNT_IDX);
  localparam logic [TQD_ADDR_W-1:0] A_YCNT = tqd_byte_addr(TQD_YCNT_IDX);
  localparam logic [TQD_ADDR_W-1:0] A_DIV = tqd_byte_addr(TQD_DIV_IDX);
  localparam logic [TQD_ADDR_W-1:0] A_SEL = tqd_byte_addr(TQD_SEL_IDX);
  localparam logic [TQD_ADDR_W-1:0] A_ZCNT = tqd_byte_addr(TQD_ZCNT_IDX);
  localparam logic [TQD_ADDR_W-1:0] A_TALLY = tqd_byte_addr(TQD_TALLY_IDX);

  logic [TQD_PINS-1:0] pinMeta, pinSync;
  logic [7:0] threshold, tally, next_tally;
  logic [9:0] divider, divCount;
  logic [11:0] pinModeSel;
  logic [15:0] axisCount [TQD_AXES];
  logic [TQD_AXES-1:0] axisEvent, axisHit;
  logic pending, unmask, prescale, preToggle, rawTick, tick, anyHit, next_pending, next_unmask;
  logic awReady, wReady, awHeld, wHeld, bValid, arReady, rValid, doWrite, wMapped, next_rOk;
  logic [TQD_ADDR_W-1:0] wAddr;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp, eventSum;
  logic [15:0] laneMask, wSet, next_rWord;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= gpioIn;
      pinSync <= pinMeta;
    end
  end

  // ****************************************************************
  // Logic clock enable
  // ****************************************************************
  // A one-cycle enable instead of a derived clock keeps one clock domain
  assign rawTick = lowPowerClock || (divCount == 10'h000);
  assign tick = rawTick && (!prescale || preToggle);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      divCount <= TQD_DIV_RST;
    end else if (lowPowerClock || divCount == 10'h000) begin
      divCount <= divider;
    end else begin
      divCount <= divCount - 10'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      preToggle <= 1'b0;
    end else if (!prescale) begin
      preToggle <= 1'b0;
    end else if (rawTick) begin
      preToggle <= !preToggle;
    end
  end

  // ****************************************************************
  // Axis channels
  // ****************************************************************
  for (genvar ax = 0; ax < TQD_AXES; ax++) begin : g_axis
    tqd_axis u_axis (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(tick),
      .pinSel(pinModeSel[TQD_SEL_X_LSB+3*ax +: 3]),
      .edgeMode(pinModeSel[TQD_MODE_X_BIT+ax]),
      .pins(pinSync),
      .threshold(threshold),
      .gaugeClear(anyHit),
      .count(axisCount[ax]),
      .event_(axisEvent[ax]),
      .hit(axisHit[ax])
    );
  end
  assign anyHit = |axisHit;

  // ****************************************************************
  // Bus write side
  // ****************************************************************
  assign doWrite = awHeld && wHeld && !bValid;

  always_comb begin
    laneMask = {{8{wStrb[1]}}, {8{wStrb[0]}}};
    wSet = wData[15:0] & laneMask;
    wMapped = (wAddr == A_CTRL) || (wAddr == A_XCNT) || (wAddr == A_YCNT) ||
              (wAddr == A_DIV) || (wAddr == A_SEL) || (wAddr == A_ZCNT) ||
              (wAddr == A_TALLY);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awReady <= 1'b1;
      wAddr <= '0;
    end else if (axiReq.awvalid && awReady) begin
      awHeld <= 1'b1;
      awReady <= 1'b0;
      wAddr <= axiReq.awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
      awReady <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wHeld <= 1'b0;
      wReady <= 1'b1;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
    end else if (axiReq.wvalid && wReady) begin
      wHeld <= 1'b1;
      wReady <= 1'b0;
      wData <= axiReq.wdata;
      wStrb <= axiReq.wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
      wReady <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bValid <= 1'b0;
      bResp <= TQD_RESP_OKAY;
    end else if (doWrite) begin
      bValid <= 1'b1;
      bResp <= wMapped ? TQD_RESP_OKAY : TQD_RESP_SLVERR;
    end else if (axiReq.bready) begin
      bValid <= 1'b0;
    end
  end

  // ****************************************************************
  // Software-written settings
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      threshold <= TQD_THR_RST;
      unmask <= TQD_UNMASK_RST;
    end else if (doWrite && wAddr == A_CTRL) begin
      if (wStrb[0]) begin
        threshold[4:0] <= wData[7:TQD_CTRL_THR_LSB];
        unmask <= wData[TQD_CTRL_UNMASK_BIT];
      end
      if (wStrb[1]) begin
        threshold[7:5] <= wData[TQD_CTRL_THR_MSB:8];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      divider <= TQD_DIV_RST;
      prescale <= TQD_PRESC_RST;
    end else if (doWrite && wAddr == A_DIV) begin
      if (wStrb[0]) begin
        divider[7:0] <= wData[7:0];
      end
      if (wStrb[1]) begin
        divider[9:8] <= wData[TQD_DIV_MSB:8];
        prescale <= wData[TQD_DIV_PRESC_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinModeSel <= TQD_SEL_RST;
    end else if (doWrite && wAddr == A_SEL) begin
      pinModeSel <= (pinModeSel & ~laneMask[11:0]) | wSet[11:0];
    end
  end

  // ****************************************************************
  // Pending flag, tally, interrupt
  // ****************************************************************
  always_comb begin
    eventSum = 2'(axisEvent[0]) + 2'(axisEvent[1]) + 2'(axisEvent[2]);
    next_pending = pending;
    if (doWrite && wAddr == A_CTRL && wSet[TQD_CTRL_PEND_BIT]) begin
      next_pending = 1'b0;
    end
    // A threshold hit in the clearing cycle still pends
    if (anyHit) begin
      next_pending = 1'b1;
    end
    next_tally = tally + {6'h00, eventSum};
    if (doWrite && wAddr == A_CTRL && wSet[TQD_CTRL_TCLR_BIT]) begin
      next_tally = {6'h00, eventSum};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pending <= 1'b0;
      tally <= 8'h00;
    end else begin
      pending <= next_pending;
      tally <= next_tally;
    end
  end

  // Uses the next values so the pin follows pending and unmask with no lag
  assign next_unmask = (doWrite && wAddr == A_CTRL && wStrb[0]) ?
                       wData[TQD_CTRL_UNMASK_BIT] : unmask;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_pending && next_unmask;
    end
  end

  // ****************************************************************
  // Bus read side
  // ****************************************************************
  always_comb begin
    next_rWord = 16'h0000;
    next_rOk = 1'b1;
    if (axiReq.araddr == A_CTRL) begin
      // The tally clear bit always reads zero
      next_rWord = {5'h00, threshold, pending, 1'b0, unmask};
    end else if (axiReq.araddr == A_XCNT) begin
      next_rWord = axisCount[0];
    end else if (axiReq.araddr == A_YCNT) begin
      next_rWord = axisCount[1];
    end else if (axiReq.araddr == A_DIV) begin
      next_rWord = {5'h00, prescale, divider};
    end else if (axiReq.araddr == A_SEL) begin
      next_rWord = {4'h0, pinModeSel};
    end else if (axiReq.araddr == A_ZCNT) begin
      next_rWord = axisCount[2];
    end else if (axiReq.araddr == A_TALLY) begin
      next_rWord = {8'h00, tally};
    end else begin
      next_rOk = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arReady <= 1'b1;
      rValid <= 1'b0;
      rData <= 32'h00000000;
      rResp <= TQD_RESP_OKAY;
    end else if (axiReq.arvalid && arReady) begin
      arReady <= 1'b0;
      rValid <= 1'b1;
      rData <= {16'h0000, next_rWord};
      rResp <= next_rOk ? TQD_RESP_OKAY : TQD_RESP_SLVERR;
    end else if (rValid && axiReq.rready) begin
      arReady <= 1'b1;
      rValid <= 1'b0;
    end
  end

  assign axiRsp = '{awready: awReady, wready: wReady, bresp: bResp, bvalid: bValid,
                    arready: arReady, rdata: rData, rresp: rResp, rvalid: rValid};
endmodule // tqd_decoder

`default_nettype wire

// file: tqd_properties.sv
// Concurrent checks on the quadrature decoder ports
`timescale 1ns/1ps
`default_nettype none
module tqd_properties
  import tqd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire tqd_axi_req_t axiReq,
  input wire tqd_axi_rsp_t axiRsp,
  input wire logic [TQD_PINS-1:0] gpioIn,
  input wire logic lowPowerClock,
  input wire logic irq
);
  // ****************************************************************
  // Bus and interrupt properties
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic wrTake = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  wire logic rdTake = axiReq.arvalid && axiRsp.arready;
  wire logic unmaskOff = wrTake && axiReq.awaddr == 12'h000 && axiReq.wstrb[0] && !axiReq.wdata[0];

  a_write_answer: assert property (wrTake |-> ##[1:2] axiRsp.bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response dropped");
  a_read_answer: assert property (rdTake |=> axiRsp.rvalid && !axiRsp.arready)
    else $error("read response missing");
  a_rdata_hold: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data not held");
  a_unmapped_error: assert property (rdTake && (axiReq.araddr > 12'h030 || axiReq.araddr[2:0] != 3'h0)
    |=> axiRsp.rresp == TQD_RESP_SLVERR && axiRsp.rdata == 32'h00000000)
    else $error("unmapped read not refused");
  a_count_width: assert property (axiRsp.rvalid |-> axiRsp.rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_mask_drops_irq: assert property (unmaskOff |-> ##[1:3] !irq)
    else $error("masked interrupt still high");
  a_irq_after_reset: assert property ($rose(rst_n) |-> !irq)
    else $error("interrupt high out of reset");
endmodule // tqd_properties
`default_nettype wire

// file: tqd_sensor_model.sv
// Behavioural quadrature sensor driving one pin pair
`timescale 1ns/1ps
`default_nettype none
module tqd_sensor_model
  import tqd_pkg::*;
#(
  parameter int PAIR = 1
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic stepReq,
  input wire logic [1:0] stepBy,
  output logic [TQD_PINS-1:0] pins
);
  // ****************************************************************
  // Phase walk
  // ****************************************************************
  logic [1:0] phase;
  // Gray walk moves one phase per step; a step of 2 moves both at once
  always_ff @(posedge sys_clk) begin
    if (!rst_n) phase <= 2'd0;
    else if (stepReq) phase <= phase + stepBy;
  end
  // Pins of other pairs sit low as if pulled down
  always_comb begin
    pins = '0;
    pins[TQD_PIN_A[PAIR]] = phase[1];
    pins[TQD_PIN_B[PAIR]] = phase[1] ^ phase[0];
  end
endmodule // tqd_sensor_model
`default_nettype wire

// file: tb.sv
// Self-checking bench for the three-axis quadrature decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin failCount++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb
  import tqd_pkg::*;
;
  // ****************************************************************
  // Signals, instances, clock
  // ****************************************************************
  logic sys_clk, rst_n, lowPowerClock, irq, stepReq, pending, unmask;
  tqd_axi_req_t axiReq;
  tqd_axi_rsp_t axiRsp;
  logic [TQD_PINS-1:0] gpioIn;
  logic [1:0] stepBy, resp;
  int failCount = 0, checkCount = 0, cycles = 0, expX = 0, tally = 0, gauge = 0, thr = 2;
  int xMode = 1, xOn = 1;
  logic [11:0] regA [6] = '{12'h008, 12'h010, 12'h018, 12'h020, 12'h028, 12'h030};
  logic [15:0] regV [6] = '{16'h0000, 16'h0000, 16'h03e7, 16'h0ed1, 16'h0000, 16'h0000};

  tqd_decoder u_tqd_decoder (.sys_clk(sys_clk), .rst_n(rst_n), .axiReq(axiReq),
    .axiRsp(axiRsp), .gpioIn(gpioIn), .lowPowerClock(lowPowerClock), .irq(irq));
  tqd_sensor_model u_tqd_sensor_model (.sys_clk(sys_clk), .rst_n(rst_n), .stepReq(stepReq),
    .stepBy(stepBy), .pins(gpioIn));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failCount++;
      wrapUp();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [15:0] ctrlExp();
    return {5'h00, thr[7:0], pending, 1'b0, unmask};
  endfunction

  // Ready lines are raised late on purpose so held responses are exercised
  task automatic axiWr(input logic [11:0] a, input logic [15:0] d);
    logic aw, w, b;
    int k;
    k = 0;
    @(posedge sys_clk);
    axiReq.awaddr <= a;
    axiReq.wdata <= {16'h0000, d};
    axiReq.wstrb <= 4'h3;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    do begin
      @(negedge sys_clk);
      aw = axiReq.awvalid && axiRsp.awready;
      w = axiReq.wvalid && axiRsp.wready;
      b = axiReq.bready && axiRsp.bvalid;
      resp = axiRsp.bresp;
      k++;
      @(posedge sys_clk);
      if (aw) axiReq.awvalid <= 1'b0;
      if (w) axiReq.wvalid <= 1'b0;
      axiReq.bready <= !b && k > 2;
    end while (!b);
    `CHK("bresp", TQD_RESP_OKAY, resp)
  endtask

  task automatic axiRd(input logic [11:0] a, input logic [1:0] er, input logic [15:0] ed);
    logic ar, r;
    logic [31:0] dat;
    int k;
    k = 0;
    @(posedge sys_clk);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    do begin
      @(negedge sys_clk);
      ar = axiReq.arvalid && axiRsp.arready;
      r = axiReq.rready && axiRsp.rvalid;
      dat = axiRsp.rdata;
      resp = axiRsp.rresp;
      k++;
      @(posedge sys_clk);
      if (ar) axiReq.arvalid <= 1'b0;
      axiReq.rready <= !r && k > 1;
    end while (!r);
    `CHK("rresp", er, resp)
    `CHK("rdata", {16'h0000, ed}, dat)
  endtask

  // Moves the sensor by `by` for `hold` cycles, then updates the expected state
  task automatic step(input logic [1:0] by, input int hold = 1, input int waitC = 8);
    int d;
    logic [1:0] net;
    @(posedge sys_clk);
    stepReq <= 1'b1;
    stepBy <= by;
    repeat (hold) @(posedge sys_clk);
    stepReq <= 1'b0;
    repeat (waitC) @(posedge sys_clk);
    net = 2'(by * hold);
    d = (net == 2'd3) ? -1 : 1;
    if (net == 2'd0) d = 0;
    else if (xMode == 1) d = 1;
    else if (net == 2'd2) d = 0;
    if (xOn == 1 && d != 0) begin
      expX = (expX + d) & 16'hffff;
      tally = (tally + 1) & 8'hff;
      if (gauge >= thr) begin
        pending = 1'b1;
        gauge = 0;
      end else gauge++;
    end
    @(negedge sys_clk);
    `CHK("irq", pending & unmask, irq)
    axiRd(12'h008, TQD_RESP_OKAY, expX[15:0]);
    axiRd(12'h030, TQD_RESP_OKAY, tally[15:0]);
    axiRd(12'h000, TQD_RESP_OKAY, ctrlExp());
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    axiReq = '0;
    stepReq = 1'b0;
    stepBy = 2'd0;
    lowPowerClock = 1'b1;
    pending = 1'b0;
    unmask = 1'b1;
    void'($urandom(32'h9e9f));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    axiRd(12'h000, TQD_RESP_OKAY, ctrlExp());
    foreach (regA[i]) axiRd(regA[i], TQD_RESP_OKAY, regV[i]);
    axiRd(12'h038, TQD_RESP_SLVERR, 16'h0000);
    axiRd(12'h004, TQD_RESP_SLVERR, 16'h0000);
    axiWr(12'h008, 16'h1234);
    axiRd(12'h008, TQD_RESP_OKAY, 16'h0000);
    // Edge mode with the divider bypassed by the low-power clock
    repeat ($urandom_range(8, 3)) step(2'($urandom_range(3, 1)));
    unmask = 1'b0;
    axiWr(12'h000, ctrlExp() & 16'hfffb);
    step(2'd1);
    axiWr(12'h000, {5'h00, thr[7:0], 3'b110});
    pending = 1'b0;
    tally = 0;
    axiRd(12'h000, TQD_RESP_OKAY, ctrlExp());
    axiRd(12'h030, TQD_RESP_OKAY, 16'h0000);
    thr = $urandom_range(3, 0);
    unmask = 1'b1;
    axiWr(12'h000, {5'h00, thr[7:0], 3'b001});
    repeat (5) step(2'($urandom_range(3, 1)));
    // Quadrature counting, walked back through zero
    xMode = 0;
    axiWr(12'h020, 16'h0cd1);
    while (expX != 16'hffff) step(2'd3);
    repeat (10) step(2'($urandom_range(3, 1)));
    // Divider: at 0 every cycle ticks; at reset value two quick steps merge into one
    xMode = 1;
    axiWr(12'h020, 16'h0ed1);
    // Outside bypass the countdown reloads only at zero, so load 0 while bypassed before leaving bypass
    axiWr(12'h018, 16'h0000);
    lowPowerClock <= 1'b0;
    step(2'd1);
    axiWr(12'h018, 16'h03e7);
    step(2'd1, 2, 1010);
    // Prescaler on the bypassed tick: counting still follows within the wait
    lowPowerClock <= 1'b1;
    axiWr(12'h018, 16'h0400);
    axiRd(12'h018, TQD_RESP_OKAY, 16'h0400);
    step(2'd1);
    // Disabled channel reads zero and ignores movement
    xOn = 0;
    expX = 0;
    axiWr(12'h020, 16'h0ed0);
    step(2'd1);
    axiWr(12'h020, 16'h0ed7);
    step(2'd1);
    wrapUp();
  end
endmodule // tb

bind tqd_decoder tqd_properties u_tqd_properties (.sys_clk(sys_clk), .rst_n(rst_n),
  .axiReq(axiReq), .axiRsp(axiRsp), .gpioIn(gpioIn), .lowPowerClock(lowPowerClock), .irq(irq));
`default_nettype wire
